//--- common/dccm_pkg.sv
// Shared constants and carrier types of the dual channel contact monitor.
package dccm_pkg;

    // =====================================================================
    // Clock and time base
    // =====================================================================
    // System clock rate in hertz.
    localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
    // Clock cycles in one microsecond.
    localparam int unsigned CYC_PER_US      = CLK_FREQ_HZ / 1_000_000;
    // Clock cycles in one millisecond.
    localparam int unsigned CYC_PER_MS      = CLK_FREQ_HZ / 1_000;

    // Start-up phase length in milliseconds, used for the mode check.
    localparam int unsigned STARTUP_TIME_MS = 500;
    // Start-up phase length in clock cycles.
    localparam int unsigned STARTUP_CYC     = STARTUP_TIME_MS * CYC_PER_MS;
    // Test pulse repetition period in microseconds.
    localparam int unsigned TP_PERIOD_US    = 10_000;
    // Test pulse repetition period in clock cycles.
    localparam int unsigned TP_PERIOD_CYC   = TP_PERIOD_US * CYC_PER_US;
    // Low time of one test pulse in microseconds.
    localparam int unsigned TP_WIDTH_US     = 200;
    // Low time of one test pulse in clock cycles.
    localparam int unsigned TP_WIDTH_CYC    = TP_WIDTH_US * CYC_PER_US;
    // Half period of the indicator blink in milliseconds.
    localparam int unsigned BLINK_TIME_MS   = 250;
    // Half period of the indicator blink in clock cycles.
    localparam int unsigned BLINK_CYC       = BLINK_TIME_MS * CYC_PER_MS;
    // Width of all long cycle counters.
    localparam int unsigned CNT_W           = 26;

    // =====================================================================
    // Channel layout
    // =====================================================================
    // Number of monitored contact pairs, the cascade pair included.
    localparam int unsigned NUM_PAIRS       = 4;
    // Index of the cascade pair.
    localparam int unsigned CASC_IDX        = 3;
    // Consecutive idle samples with unequal contacts that mark a partial operation.
    localparam logic [1:0]  PARTIAL_SAMPLES = 2'h2;

    // =====================================================================
    // Register map
    // =====================================================================
    // Width of the decoded APB address.
    localparam int unsigned ADDR_W          = 12;
    // Control register byte offset.
    localparam logic [11:0] CTRL_OFS        = 12'h000;
    // Status register byte offset.
    localparam logic [11:0] STATUS_OFS      = 12'h004;
    // Control field: force both safety outputs low.
    localparam int unsigned CTRL_FORCE_BIT  = 0;
    // Reset value of the force field.
    localparam logic        CTRL_FORCE_RST  = 1'b0;
    // Status field positions.
    localparam int unsigned ST_READY_BIT    = 0;
    localparam int unsigned ST_SERIES_BIT   = 1;
    localparam int unsigned ST_FAULT_BIT    = 2;
    localparam int unsigned ST_SAFE_BIT     = 3;
    localparam int unsigned ST_SENSOR_BIT   = 4;
    localparam int unsigned ST_CLOSED_LSB   = 8;
    localparam int unsigned ST_PARTIAL_LSB  = 12;
    localparam int unsigned ST_SHORT_LSB    = 16;

    // =====================================================================
    // Carrier types
    // =====================================================================
    // The two contact inputs of one pair.
    typedef struct packed {
        logic a;    // First contact, fed by test pulse A.
        logic b;    // Second contact, fed by test pulse B.
    } dccm_pins_type;

    // The evaluated state of one pair.
    typedef struct packed {
        logic closed;       // Both contacts closed and no partial fault.
        logic partial;      // Pair seen partially operated.
        logic short_fault;  // Latched short or swapped pulse.
    } dccm_chan_status_type;

endpackage

//--- dv/dccm_chk_sva.sv
// Port checker of the contact monitor.
`timescale 1ns/1ps
module dccm_chk (
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        test_pulse_a_o,
    input wire logic        test_pulse_b_o,
    input wire logic        safety_out_a_o,
    input wire logic        safety_out_b_o,
    input wire logic        sensor_state_o,
    input wire logic        led_power_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_out_pair: assert property (safety_out_a_o == safety_out_b_o) else $error("pair");
    a_pulse_apart: assert property ($past(nrst_i) |-> test_pulse_a_o || test_pulse_b_o) else $error("tp");
    a_safe_ready: assert property (safety_out_a_o |-> sensor_state_o && led_power_o) else $error("so");
    a_blink_quiet: assert property ($fell(led_power_o) |-> !safety_out_a_o && !sensor_state_o) else $error("pw");
    a_power_held: assert property (safety_out_a_o && led_power_o |=> led_power_o) else $error("hold");
    a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("rdy");
    a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("wait");
    a_unmapped_err: assert property (pready_o |-> pslverr_o == (paddr_i > 12'h004 || paddr_i[1:0] != 2'h0)) else $error("err");
endmodule // dccm_chk

//--- dv/dccm_sensor_model.sv
// Sensors with two normally open contacts wired to the test pulses.
`timescale 1ns/1ps
module dccm_sensor_model (
    input  wire logic       test_pulse_a_i, // Pulse for first contacts.
    input  wire logic       test_pulse_b_i, // Pulse for second contacts.
    input  wire logic [7:0] sw_i,           // Contact closed, pair i at bits 2i+1:2i.
    input  wire logic [3:0] swap_i,         // Pair wired with its pulses crossed.
    output logic      [7:0] pins_o          // Contact levels at the monitor.
);
    // A closed contact passes its pulse, an open one reads low; spare pairs loop back alike.
    always_comb for (int i = 0; i < 4; i++) begin
        pins_o[2*i] = sw_i[2*i] & (swap_i[i] ? test_pulse_b_i : test_pulse_a_i);
        pins_o[2*i+1] = sw_i[2*i+1] & (swap_i[i] ? test_pulse_a_i : test_pulse_b_i);
    end
endmodule // dccm_sensor_model

//--- dv/tb_dual_channel_contact_monitor.sv
// Self-checking bench of the contact monitor.
`timescale 1ns/1ps
bind dccm_top dccm_chk i_chk (.*);
module tb_dual_channel_contact_monitor;
    logic clk_sys_i = 0, nrst_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic chan1_contact_a_i, chan1_contact_b_i, chan2_contact_a_i, chan2_contact_b_i, pready_o;
    logic chan3_contact_a_i, chan3_contact_b_i, cascade_in_a_i, cascade_in_b_i, pslverr_o;
    logic test_pulse_a_o, test_pulse_b_o, safety_out_a_o, safety_out_b_o, sensor_state_o;
    logic led_power_o, led_safety_a_o, led_safety_b_o;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o;
    logic [7:0] sw = 8'hFF, pins;
    logic [3:0] led_pair_o, swap = 0;
    logic [33:0] q[$];
    int errors = 0, n_checks = 0, k, c;
    initial forever #5 clk_sys_i = ~clk_sys_i;
    dccm_top #(.STARTUP_CYC(200), .TP_PERIOD_CYC(100), .TP_WIDTH_CYC(10), .BLINK_CYC(8)) i_dut (.*);
    dccm_sensor_model i_snr (.test_pulse_a_i(test_pulse_a_o), .test_pulse_b_i(test_pulse_b_o),
        .sw_i(sw), .swap_i(swap), .pins_o(pins));
    assign {cascade_in_b_i, cascade_in_a_i, chan3_contact_b_i, chan3_contact_a_i} = pins[7:4];
    assign {chan2_contact_b_i, chan2_contact_a_i, chan1_contact_b_i, chan1_contact_a_i} = pins[3:0];
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        q.push_back(e);
        @(posedge clk_sys_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge clk_sys_i);
        penable_i <= 1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        {psel_i, penable_i} <= 2'h0;
    endtask
    // Pops the oldest expected answer at every completed transfer.
    always @(posedge clk_sys_i) if (psel_i && penable_i && pready_o === 1'b1) begin
        chk("pslverr", pslverr_o, q[0][32]);
        if (q[0][33]) chk("prdata", prdata_o, q[0][31:0]);
        void'(q.pop_front());
    end
    function automatic logic [31:0] st(logic [3:0] cl, logic [3:0] pa, logic [4:0] f);
        return {16'h0, pa, cl, 3'h0, f};
    endfunction
    task automatic settle;
        repeat (120) @(posedge clk_sys_i);
    endtask
    task automatic give_verdict;
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hB38DA95F));
        k = $urandom_range(2, 0);
        c = $urandom_range(1, 0);
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1;
        repeat (260) @(posedge clk_sys_i);
        apb(0, 12'h004, 0, {2'h2, st(4'hF, 4'h0, 5'h19)});
        sw[2*k+c] <= 0;
        settle();
        apb(0, 12'h004, 0, {2'h2, st(4'hF ^ (4'h1 << k), 4'h1 << k, 5'h01)});
        sw[2*k+c] <= 1;
        settle();
        chk("safety_out_a", safety_out_a_o, 0);
        sw[2*k +: 2] <= 2'h0;
        settle();
        sw[2*k +: 2] <= 2'h3;
        settle();
        chk("safety_out_b", safety_out_b_o, 1);
        chk("led_safety_a", led_safety_a_o, 1);
        sw[7:6] <= 2'h0;
        settle();
        chk("safety_out_a", safety_out_a_o, 0);
        chk("sensor_state", sensor_state_o, 1);
        chk("led_pair", led_pair_o, 4'h7);
        sw[7:6] <= 2'h3;
        settle();
        apb(1, 12'h000, 1, 0);
        apb(0, 12'h008, 0, {2'h3, 32'h0});
        chk("safety_out_a", safety_out_a_o, 0);
        apb(1, 12'h000, 0, 0);
        swap[k] <= 1;
        settle();
        swap[k] <= 0;
        settle();
        chk("safety_out_a", safety_out_a_o, 0);
        chk("sensor_state", sensor_state_o, 0);
        give_verdict();
    end
endmodule // tb_dual_channel_contact_monitor

//--- verilog/dccm_channel.sv
// Evaluation of one dual-channel contact pair.
`timescale 1ns/1ps

module dccm_channel (
    input  wire logic                          clk_sys_i,     // System clock.
    input  wire logic                          nrst_i,        // Asynchronous reset, active low.
    input  wire logic                          ce_i,          // Clock enable.
    input  wire dccm_pkg::dccm_pins_type       pins_i,        // Synchronised contact inputs.
    input  wire logic                          sample_idle_i, // Sample point outside any pulse.
    input  wire logic                          check_a_i,     // Last cycle of pulse A.
    input  wire logic                          check_b_i,     // Last cycle of pulse B.
    input  wire logic                          pulse_en_i,    // Pulse checks apply to this pair.
    output dccm_pkg::dccm_chan_status_type     status_o       // Evaluated pair state.
);

    // =====================================================================
    // State
    // =====================================================================
    // All state of the pair in one record.
    typedef struct packed {
        logic       a_closed;    // Contact A high at last idle sample.
        logic       b_closed;    // Contact B high at last idle sample.
        logic [1:0] mism_cnt;    // Consecutive unequal idle samples.
        logic       partial;     // Partial operation flagged.
        logic       seen_open;   // Both contacts seen open while partial.
        logic       short_fault; // Latched until reset.
    } dccm_chan_state_type;

    dccm_chan_state_type s;      // Present state.
    dccm_chan_state_type next_s; // Next state.

    // Next-state logic of the pair.
    always_comb begin
        next_s = s;
        if (sample_idle_i) begin
            // Outside pulses a closed contact reads high and an open one low.
            next_s.a_closed = pins_i.a;
            next_s.b_closed = pins_i.b;
            if (pins_i.a != pins_i.b) begin
                // Unequal contacts longer than the tolerance mark a partial operation.
                if (s.mism_cnt < dccm_pkg::PARTIAL_SAMPLES - 2'h1) begin
                    next_s.mism_cnt = s.mism_cnt + 2'h1;
                end else begin
                    next_s.partial = 1'b1; // R12
                end
            end else begin
                next_s.mism_cnt = 2'h0;
            end
            if (s.partial) begin
                // The partial fault clears only after both open, then both closed.
                if (!pins_i.a && !pins_i.b) begin
                    next_s.seen_open = 1'b1; // R13
                end else if (pins_i.a && pins_i.b && s.seen_open) begin
                    next_s.partial   = 1'b0; // R13
                    next_s.seen_open = 1'b0;
                    next_s.mism_cnt  = 2'h0;
                end
            end
        end
        // A closed contact that does not follow its own pulse is shorted or swapped.
        if (pulse_en_i && check_a_i && s.a_closed && pins_i.a) begin
            next_s.short_fault = 1'b1; // R19
        end
        if (pulse_en_i && check_b_i && s.b_closed && pins_i.b) begin
            next_s.short_fault = 1'b1; // R19
        end
    end

    // State register; the short fault is left only by reset.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s; // R11
        end
    end

    // Pair result as seen by the top level.
    assign status_o.closed      = s.a_closed & s.b_closed & ~s.partial;
    assign status_o.partial     = s.partial;
    assign status_o.short_fault = s.short_fault;

endmodule // dccm_channel

//--- verilog/dccm_top.sv
// Top level of the dual channel contact monitor with its APB register slave.
//
// Operation
// R1 - Pulse A feeds contact A, pulse B contact B.
// R2 - Unused channels loop back to own pulse.
// R3 - Cascade pair driven only by upstream outputs.
// R4 - Sensor-state output ignores the cascade pair; the code still drops it on a cascade pair short fault.
// R5 - Start-up phase decides stand-alone or series mode.
// R6 - Power indicator steady only when ready.
// R7 - Power indicator blinks during mode check.
// R8 - Safety indicators follow safety output levels.
// R9 - Pair indicator differs for open and closed.
// R10 - Short fault blinks the safety indicators.
// R11 - Short fault latched until power cycle.
// R12 - One contact closed flags partial operation.
// R13 - Partial clears after both open, both closed.
// R14 - Outputs rise within 40 ms of closing.
// R15 - Outputs fall within 40 ms of opening.
// R16 - Exactly two independent test pulse outputs.
// R17 - Outputs high only while all pairs closed.
// R18 - Sensor-state high only when all sensors closed.
// R19 - Swapped or shorted pulses force outputs low.
// R20 - Safety outputs are AND of all pairs.
// R21 - Test pulses are low-going, never overlapping.
// R22 - Outputs low during start-up and faults.
`timescale 1ns/1ps

module dccm_top #(
    parameter int unsigned STARTUP_CYC   = dccm_pkg::STARTUP_CYC,   // Start-up phase length.
    parameter int unsigned TP_PERIOD_CYC = dccm_pkg::TP_PERIOD_CYC, // Test pulse period.
    parameter int unsigned TP_WIDTH_CYC  = dccm_pkg::TP_WIDTH_CYC,  // Test pulse low time.
    parameter int unsigned BLINK_CYC     = dccm_pkg::BLINK_CYC      // Blink half period.
) (
    input  wire logic        clk_sys_i,         // System clock, 100 MHz.
    input  wire logic        nrst_i,            // Asynchronous reset, active low.
    input  wire logic        ce_i,              // Clock enable; low freezes all state.
    input  wire logic        chan1_contact_a_i, // Sensor 1, first contact.
    input  wire logic        chan1_contact_b_i, // Sensor 1, second contact.
    input  wire logic        chan2_contact_a_i, // Sensor 2, first contact.
    input  wire logic        chan2_contact_b_i, // Sensor 2, second contact.
    input  wire logic        chan3_contact_a_i, // Sensor 3, first contact.
    input  wire logic        chan3_contact_b_i, // Sensor 3, second contact.
    input  wire logic        cascade_in_a_i,    // Cascade or sensor 4, first contact.
    input  wire logic        cascade_in_b_i,    // Cascade or sensor 4, second contact.
    input  wire logic        psel_i,            // APB select.
    input  wire logic        penable_i,         // APB enable.
    input  wire logic        pwrite_i,          // APB direction, high for write.
    input  wire logic [11:0] paddr_i,           // APB byte address.
    input  wire logic [31:0] pwdata_i,          // APB write data.
    output logic      [31:0] prdata_o,          // APB read data.
    output logic             pready_o,          // APB ready.
    output logic             pslverr_o,         // APB error for unmapped address.
    output logic             test_pulse_a_o,    // Test pulse for all first contacts.
    output logic             test_pulse_b_o,    // Test pulse for all second contacts.
    output logic             safety_out_a_o,    // First safety output.
    output logic             safety_out_b_o,    // Second safety output.
    output logic             sensor_state_o,    // Local sensors all operated.
    output logic             led_power_o,       // Power and readiness indicator.
    output logic             led_safety_a_o,    // Indicator of the first safety output.
    output logic             led_safety_b_o,    // Indicator of the second safety output.
    output logic      [3:0]  led_pair_o         // Indicator per contact pair.
);

    // =====================================================================
    // Types and state
    // =====================================================================
    // All state of the top level in one record.
    typedef struct packed {
        dccm_pkg::dccm_pins_type [dccm_pkg::NUM_PAIRS-1:0] sync1; // First sync stage.
        dccm_pkg::dccm_pins_type [dccm_pkg::NUM_PAIRS-1:0] sync2; // Second sync stage.

        logic [dccm_pkg::CNT_W-1:0] tp_cnt;    // Position in the test pulse period.
        logic [dccm_pkg::CNT_W-1:0] start_cnt; // Elapsed start-up cycles.
        logic [dccm_pkg::CNT_W-1:0] blink_cnt; // Blink half period counter.

        logic        blink;       // Blink phase.
        logic        ready;       // Start-up finished.
        logic        series;      // Fed from an upstream unit.
        logic        loop_a_seen; // Cascade pair followed pulse A during start-up.
        logic        loop_b_seen; // Cascade pair followed pulse B during start-up.

        logic        force_safe;  // Control field: hold safety outputs low.
        logic        tp_a;        // Test pulse A pin level.
        logic        tp_b;        // Test pulse B pin level.

        logic        safe_a;      // Safety output A.
        logic        safe_b;      // Safety output B.
        logic        sensor;      // Sensor-state output.

        logic        led_power;   // Power indicator.
        logic        led_safe_a;  // Safety indicator A.
        logic        led_safe_b;  // Safety indicator B.
        logic [3:0]  led_pair;    // Pair indicators.

        logic        pready;      // APB ready.
        logic        pslverr;     // APB error.
        logic [31:0] prdata;      // APB read data.
    } dccm_top_state_type;

    dccm_top_state_type s;      // Present state.
    dccm_top_state_type next_s; // Next state.

    // Pulse phase strobes shared with all pairs.
    logic sample_idle; // Sample point in the last cycle before each pulse starts.
    logic check_a;     // Last cycle of the pulse A window.
    logic check_b;     // Last cycle of the pulse B window.

    // Results of the four pairs.
    dccm_pkg::dccm_chan_status_type [dccm_pkg::NUM_PAIRS-1:0] chan_st;
    logic [dccm_pkg::NUM_PAIRS-1:0] pulse_en; // Pulse checks enabled per pair.
    logic [dccm_pkg::NUM_PAIRS-1:0] closed;   // Pair closed per pair.
    logic [dccm_pkg::NUM_PAIRS-1:0] partial;  // Partial fault per pair.
    logic [dccm_pkg::NUM_PAIRS-1:0] shorted;  // Short fault per pair.

    // Half of the pulse period; pulse B starts there.
    localparam logic [dccm_pkg::CNT_W-1:0] TP_HALF = dccm_pkg::CNT_W'(TP_PERIOD_CYC / 2);

    // =====================================================================
    // Pulse phase strobes
    // =====================================================================
    // Checks fall at the end of each pulse, after the sync delay has passed.
    assign check_a     = s.tp_cnt == dccm_pkg::CNT_W'(TP_WIDTH_CYC - 1);
    assign check_b     = s.tp_cnt == TP_HALF + dccm_pkg::CNT_W'(TP_WIDTH_CYC - 1);
    assign sample_idle = (s.tp_cnt == TP_HALF - 1) ||
                         (s.tp_cnt == dccm_pkg::CNT_W'(TP_PERIOD_CYC - 1));

    // =====================================================================
    // Pair evaluation
    // =====================================================================
    // One evaluator per pair; the cascade pair is pulse checked only stand-alone.
    for (genvar i = 0; i < dccm_pkg::NUM_PAIRS; i++) begin : g_pair
        if (i == dccm_pkg::CASC_IDX) begin : g_casc
            assign pulse_en[i] = s.ready & ~s.series; // R3
        end else begin : g_local
            assign pulse_en[i] = 1'b1; // R2
        end
        assign closed[i]  = chan_st[i].closed;
        assign partial[i] = chan_st[i].partial;
        assign shorted[i] = chan_st[i].short_fault;

        dccm_channel u_channel (
            .clk_sys_i     (clk_sys_i),
            .nrst_i        (nrst_i),
            .ce_i          (ce_i),
            .pins_i        (s.sync2[i]),
            .sample_idle_i (sample_idle),
            .check_a_i     (check_a),
            .check_b_i     (check_b),
            .pulse_en_i    (pulse_en[i]),
            .status_o      (chan_st[i])
        );
    end

    // =====================================================================
    // Next-state logic
    // =====================================================================
    // Pulses, start-up, output decisions, indicators and the APB slave.
    always_comb begin
        logic        all_closed; // Every pair closed.
        logic        local_ok;   // Every local sensor pair closed.
        logic        any_short;  // Any latched short fault.
        logic [31:0] status_w;   // Status register image.
        all_closed = &closed;
        local_ok   = &closed[dccm_pkg::CASC_IDX-1:0];
        any_short  = |shorted;
        status_w   = 32'h0000_0000;
        next_s     = s;

        // Two-stage synchronisers for all contact pins.
        next_s.sync1[0] = '{a: chan1_contact_a_i, b: chan1_contact_b_i};
        next_s.sync1[1] = '{a: chan2_contact_a_i, b: chan2_contact_b_i};
        next_s.sync1[2] = '{a: chan3_contact_a_i, b: chan3_contact_b_i};
        next_s.sync1[3] = '{a: cascade_in_a_i, b: cascade_in_b_i};
        next_s.sync2    = s.sync1;

        // Period counter; pulse A at the start, pulse B at the half.
        if (s.tp_cnt == dccm_pkg::CNT_W'(TP_PERIOD_CYC - 1)) begin
            next_s.tp_cnt = '0;
        end else begin
            next_s.tp_cnt = s.tp_cnt + 1'b1;
        end
        next_s.tp_a = ~(s.tp_cnt < dccm_pkg::CNT_W'(TP_WIDTH_CYC)); // R16 R21 R1
        next_s.tp_b = ~((s.tp_cnt >= TP_HALF) &&
                        (s.tp_cnt < TP_HALF + dccm_pkg::CNT_W'(TP_WIDTH_CYC))); // R16 R21 R1

        // Free-running blink for indicator patterns.
        if (s.blink_cnt == dccm_pkg::CNT_W'(BLINK_CYC - 1)) begin
            next_s.blink_cnt = '0;
            next_s.blink     = ~s.blink;
        end else begin
            next_s.blink_cnt = s.blink_cnt + 1'b1;
        end

        // Start-up: a looped-back cascade pair follows our own pulses.
        if (!s.ready) begin
            if (check_a && !s.sync2[dccm_pkg::CASC_IDX].a && s.sync2[dccm_pkg::CASC_IDX].b) begin
                next_s.loop_a_seen = 1'b1; // R5
            end

            if (check_b && s.sync2[dccm_pkg::CASC_IDX].a && !s.sync2[dccm_pkg::CASC_IDX].b) begin
                next_s.loop_b_seen = 1'b1; // R5
            end

            if (s.start_cnt == dccm_pkg::CNT_W'(STARTUP_CYC - 1)) begin
                // Mode is fixed here and kept until the next reset.
                next_s.ready  = 1'b1; // R5
                next_s.series = ~(s.loop_a_seen & s.loop_b_seen); // R5
            end else begin
                next_s.start_cnt = s.start_cnt + 1'b1;
            end
        end

        // Safety outputs: AND of all pairs, low in start-up and on faults.
        next_s.safe_a = s.ready & ~any_short & all_closed & ~s.force_safe; // R17 R20 R22 R14 R15
        next_s.safe_b = s.ready & ~any_short & all_closed & ~s.force_safe; // R17 R20 R22 R19

        // Sensor state takes closed from the three local pairs and short faults from all four.
        next_s.sensor = s.ready & ~any_short & local_ok; // R4 R18 R22

        // Indicators.
        next_s.led_power  = s.ready | s.blink; // R6 R7
        next_s.led_safe_a = any_short ? s.blink : next_s.safe_a; // R8 R10
        next_s.led_safe_b = any_short ? s.blink : next_s.safe_b; // R8 R10

        for (int i = 0; i < dccm_pkg::NUM_PAIRS; i++) begin
            next_s.led_pair[i] = partial[i] ? s.blink : closed[i]; // R9 R12
        end

        // Status register image.
        status_w[dccm_pkg::ST_READY_BIT]  = s.ready;
        status_w[dccm_pkg::ST_SERIES_BIT] = s.series;
        status_w[dccm_pkg::ST_FAULT_BIT]  = any_short;
        status_w[dccm_pkg::ST_SAFE_BIT]   = s.safe_a;
        status_w[dccm_pkg::ST_SENSOR_BIT] = s.sensor;

        // Each pair reports closed, partial and short.
        for (int i = 0; i < dccm_pkg::NUM_PAIRS; i++) begin
            status_w[dccm_pkg::ST_CLOSED_LSB + i]  = closed[i];
            status_w[dccm_pkg::ST_PARTIAL_LSB + i] = partial[i];
            status_w[dccm_pkg::ST_SHORT_LSB + i]   = shorted[i];
        end

        // APB: one wait state, answer in the second access cycle.
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;

        if (psel_i && penable_i && !s.pready) begin
            next_s.pready = 1'b1;
            unique case (paddr_i)
                dccm_pkg::CTRL_OFS: begin
                    next_s.prdata = {31'h0, s.force_safe};
                end
                dccm_pkg::STATUS_OFS: begin
                    next_s.prdata = status_w;
                end
                default: begin
                    // Unmapped addresses read zero and report an error.
                    next_s.prdata  = 32'h0000_0000;
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        // Writes take effect at the edge that completes the transfer.
        if (psel_i && penable_i && s.pready && pwrite_i && paddr_i == dccm_pkg::CTRL_OFS) begin
            next_s.force_safe = pwdata_i[dccm_pkg::CTRL_FORCE_BIT];
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    // Every field resets to zero; the clock enable freezes all of it.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s            <= '0;
            s.force_safe <= dccm_pkg::CTRL_FORCE_RST;
        end else if (ce_i) begin
            s <= next_s; // R11
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    // All outputs are state fields.
    assign prdata_o       = s.prdata;
    assign pready_o       = s.pready;
    assign pslverr_o      = s.pslverr;

    // The test pulses feed every contact.
    assign test_pulse_a_o = s.tp_a;
    assign test_pulse_b_o = s.tp_b;

    // The safety decisions leave here.
    assign safety_out_a_o = s.safe_a;
    assign safety_out_b_o = s.safe_b;
    assign sensor_state_o = s.sensor;

    // The indicators leave here.
    assign led_power_o    = s.led_power;
    assign led_safety_a_o = s.led_safe_a;
    assign led_safety_b_o = s.led_safe_b;
    assign led_pair_o     = s.led_pair;

endmodule // dccm_top
